// ---- core/spicr_pkg.sv ----
// Constants, state codes and CRC helpers shared by the serial command port.
package spicr_pkg;

    // Clock period of the local logic clock, in nanoseconds.
    localparam int CLK_PERIOD_NS = 5;

    // Longest completion time of a direct command, and its cycle count.
    localparam int CMD_TIME_US = 50;
    localparam int CMD_CYC     = (CMD_TIME_US * 1000) / CLK_PERIOD_NS;

    // Fill time of the subcommand buffer, and its cycle count.
    localparam int SUB_FILL_US  = 200;
    localparam int SUB_FILL_CYC = (SUB_FILL_US * 1000) / CLK_PERIOD_NS;

    // Width of the timing counters; both counts fit below 2**16.
    localparam int TMR_W = 16;

    // Frame lengths in link clock edges.
    localparam logic [5:0] BITS_NO_CRC = 6'h10;
    localparam logic [5:0] BITS_CRC    = 6'h18;
    localparam logic [5:0] BITS_MAX    = 6'h3F;

    // CRC polynomial x^8 + x^2 + x + 1 and its start value.
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // Reserved response patterns.
    localparam logic [15:0] RESP_ONES    = 16'hFFFF;
    localparam logic [7:0]  CRC_BAD_RESP = 8'hAA;
    localparam logic [7:0]  CRC_STALE    = 8'h00;
    localparam logic [7:0]  CRC_OSC_OFF  = 8'hFF;

    // Direction bit codes.
    localparam logic RW_READ  = 1'b0;
    localparam logic RW_WRITE = 1'b1;

    // Subcommand buffer address window.
    localparam logic [6:0] SUB_ADDR_LO = 7'h40;
    localparam logic [6:0] SUB_ADDR_HI = 7'h5F;

    // Reset levels of the synchronised link inputs: clock, select, data.
    localparam logic [2:0] LINK_IDLE = 3'h2;

    // What the outgoing buffer currently holds.
    typedef enum logic [2:0] {
        OB_STALE  = 3'b001,
        OB_CRCERR = 3'b010,
        OB_VALID  = 3'b100
    } spicr_kind_e;

    // Bit-serial CRC over two bytes, most significant bit first.
    function automatic logic [7:0] spicr_crc8(input logic [15:0] d);
        logic [7:0] c;
        logic       fb;
        c  = CRC_INIT; // R22
        fb = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            fb = c[7] ^ d[i];
            c  = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00); // R20
        end
        return c;
    endfunction : spicr_crc8

    // True for addresses inside the subcommand buffer window.
    function automatic logic spicr_sub_range(input logic [6:0] a);
        return (a >= SUB_ADDR_LO) && (a <= SUB_ADDR_HI);
    endfunction : spicr_sub_range

endpackage : spicr_pkg

// ---- core/spicr_port.sv ----
// Responder side of the serial command port with optional CRC and one-late responses.
`timescale 1ns/10ps

// Operation
// (R1) First byte: direction bit, 7-bit address, MSB first.
// (R2) Write frames carry data as second byte.
// (R3) Read frames ignore second byte except CRC.
// (R4) Controller appends CRC over first two bytes.
// (R5) Good CRC passes bytes to incoming buffer.
// (R6) Bad CRC: discard, respond 0xFFFF then 0xAA.
// (R7) Shift out outgoing buffer while shifting in.
// (R8) Unrefreshed buffer returns 0xFFFF then 0x00.
// (R9) Processed write is echoed next transaction.
// (R10) Read reply holds direction, address, data.
// (R11) Reply CRC computed over outgoing buffer bytes.
// (R12) Direct commands complete within 50 microseconds.
// (R13) Subcommand buffer not served while filling.
// (R14) Loaded subcommand buffer served byte by byte.
// (R15) Controller retries after all-ones response.
// (R16) Controller resends after 0xFFFFAA response.
// (R17) Controller retries or waits after 0xFFFF00.
// (R18) Clock idles low, sample first edge.
// (R19) Frames are 16 or 24 bits; else error.
// (R20) CRC polynomial x^8 + x^2 + x + 1.
// (R21) Oscillator off: all-ones for whole frame.
// (R22) CRC starts from zero every transaction.
module spicr_port #(
    parameter int CMD_CYC  = spicr_pkg::CMD_CYC,
    parameter int SUB_CYC  = spicr_pkg::SUB_FILL_CYC
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       sclk,
    input  wire logic       cs_n,
    input  wire logic       mosi,
    output logic            miso,
    output logic            miso_oe,
    input  wire logic       crc_en,
    input  wire logic       osc_ready,
    output logic            in_valid,
    output logic            in_rw,
    output logic [6:0]      in_addr,
    output logic [7:0]      in_data,
    input  wire logic       out_load,
    input  wire logic       out_rw,
    input  wire logic [6:0] out_addr,
    input  wire logic [7:0] out_data,
    input  wire logic       sub_fill_start,
    output logic            sub_busy,
    output logic            cmd_late,
    output logic            frame_err,
    output logic            crc_err
);

    logic                     s_sclk;
    logic                     s_cs_n;
    logic                     s_mosi;
    logic                     prev_sclk;
    logic                     prev_cs_n;
    logic                     cs_start;
    logic                     cs_end;
    logic                     sclk_rise;
    logic                     sclk_fall;
    logic [23:0]              rx_sh;
    logic [23:0]              tx_sh;
    logic [5:0]               bit_cnt;
    logic                     frame_live;
    logic                     crc_en_lat;
    logic [23:0]              tx_compose;
    logic [5:0]               frame_len;
    logic [15:0]              rx_hdr;
    logic                     len_bad;
    logic                     crc_bad;
    logic                     load_ok;
    spicr_pkg::spicr_kind_e   ob_kind;
    logic [15:0]              ob_word;
    logic [spicr_pkg::TMR_W-1:0] cmd_cnt;
    logic                     cmd_wait;
    logic [spicr_pkg::TMR_W-1:0] sub_cnt;

    logic                     next_prev_sclk;
    logic                     next_prev_cs_n;
    logic [23:0]              next_rx_sh;
    logic [23:0]              next_tx_sh;
    logic [5:0]               next_bit_cnt;
    logic                     next_frame_live;
    logic                     next_crc_en_lat;
    logic                     next_miso;
    logic                     next_miso_oe;
    logic                     next_in_valid;
    logic                     next_in_rw;
    logic [6:0]               next_in_addr;
    logic [7:0]               next_in_data;
    logic                     next_frame_err;
    logic                     next_crc_err;
    spicr_pkg::spicr_kind_e   next_ob_kind;
    logic [15:0]              next_ob_word;
    logic [spicr_pkg::TMR_W-1:0] next_cmd_cnt;
    logic                     next_cmd_wait;
    logic                     next_cmd_late;
    logic [spicr_pkg::TMR_W-1:0] next_sub_cnt;
    logic                     next_sub_busy;

    // Link pins come from another clock domain and are filtered before use.
    spicr_sync #(
        .W   (3),
        .RST (spicr_pkg::LINK_IDLE)
    ) u_sync (
        .clk  (clk),
        .nrst (nrst),
        .din  ({sclk, cs_n, mosi}),
        .dout ({s_sclk, s_cs_n, s_mosi})
    );

    // Edge events of the filtered link; clock edges count only inside a frame.
    assign cs_start  = prev_cs_n & ~s_cs_n;
    assign cs_end    = ~prev_cs_n & s_cs_n;
    assign sclk_rise = s_sclk & ~prev_sclk & ~s_cs_n; // R18
    assign sclk_fall = ~s_sclk & prev_sclk & ~s_cs_n; // R18

    // Frame checks at the rising select edge.
    assign frame_len = crc_en_lat ? spicr_pkg::BITS_CRC : spicr_pkg::BITS_NO_CRC;
    assign rx_hdr    = crc_en_lat ? rx_sh[23:8] : rx_sh[15:0];
    assign len_bad   = (bit_cnt != frame_len); // R19
    assign crc_bad   = crc_en_lat && (spicr_pkg::spicr_crc8(rx_sh[23:8]) != rx_sh[7:0]); // R4

    // A load into the subcommand window is held off while that buffer fills.
    assign load_ok = out_load && !(sub_busy && spicr_pkg::spicr_sub_range(out_addr)); // R13

    // Response word for the frame now starting; reserved patterns override the buffer.
    always_comb begin
        case (ob_kind)
            spicr_pkg::OB_VALID: begin
                tx_compose = {ob_word, spicr_pkg::spicr_crc8(ob_word)}; // R11
            end
            spicr_pkg::OB_CRCERR: begin
                tx_compose = {spicr_pkg::RESP_ONES, spicr_pkg::CRC_BAD_RESP}; // R6
            end
            default: begin
                tx_compose = {spicr_pkg::RESP_ONES, spicr_pkg::CRC_STALE}; // R8
            end
        endcase
        if (!osc_ready) begin
            tx_compose = {spicr_pkg::RESP_ONES, spicr_pkg::CRC_OSC_OFF}; // R21
        end
    end

    // Shift engine: sample on the rising link clock, change output on the falling one.
    always_comb begin
        next_prev_sclk  = s_sclk;
        next_prev_cs_n  = s_cs_n;
        next_rx_sh      = rx_sh;
        next_tx_sh      = tx_sh;
        next_bit_cnt    = bit_cnt;
        next_frame_live = frame_live;
        next_crc_en_lat = crc_en_lat;
        next_miso       = miso;
        next_miso_oe    = miso_oe;
        next_in_valid   = 1'b0;
        next_in_rw      = in_rw;
        next_in_addr    = in_addr;
        next_in_data    = in_data;
        next_frame_err  = 1'b0;
        next_crc_err    = 1'b0;
        if (cs_start) begin
            next_rx_sh      = 24'h000000;
            next_bit_cnt    = 6'h00;
            next_tx_sh      = tx_compose; // R7
            next_miso       = tx_compose[23];
            next_miso_oe    = 1'b1;
            next_frame_live = osc_ready; // R21
            next_crc_en_lat = crc_en;
        end else if (!s_cs_n) begin
            if (sclk_rise) begin
                next_rx_sh = {rx_sh[22:0], s_mosi}; // R1
                if (bit_cnt != spicr_pkg::BITS_MAX) begin
                    next_bit_cnt = bit_cnt + 6'h01;
                end
            end
            if (sclk_fall) begin
                next_tx_sh = {tx_sh[22:0], 1'b1}; // R7
                next_miso  = tx_sh[22];
            end
        end
        if (cs_end) begin
            next_miso    = 1'b0;
            next_miso_oe = 1'b0;
            // A frame begun with the oscillator off is answered but never acted on.
            if (frame_live) begin
                if (len_bad) begin
                    next_frame_err = 1'b1; // R19
                end else if (crc_bad) begin
                    next_crc_err = 1'b1; // R6
                end else begin
                    next_in_valid = 1'b1; // R5
                    next_in_rw    = rx_hdr[15]; // R1
                    next_in_addr  = rx_hdr[14:8];
                    // The second byte only means something on a write.
                    next_in_data  = (rx_hdr[15] == spicr_pkg::RW_WRITE) ? rx_hdr[7:0] : 8'h00; // R2 R3
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            prev_sclk  <= 1'b0;
            prev_cs_n  <= 1'b1;
            rx_sh      <= 24'h000000;
            tx_sh      <= 24'hFFFFFF;
            bit_cnt    <= 6'h00;
            frame_live <= 1'b0;
            crc_en_lat <= 1'b0;
            miso       <= 1'b0;
            miso_oe    <= 1'b0;
            in_valid   <= 1'b0;
            in_rw      <= 1'b0;
            in_addr    <= 7'h00;
            in_data    <= 8'h00;
            frame_err  <= 1'b0;
            crc_err    <= 1'b0;
        end else begin
            prev_sclk  <= next_prev_sclk;
            prev_cs_n  <= next_prev_cs_n;
            rx_sh      <= next_rx_sh;
            tx_sh      <= next_tx_sh;
            bit_cnt    <= next_bit_cnt;
            frame_live <= next_frame_live;
            crc_en_lat <= next_crc_en_lat;
            miso       <= next_miso;
            miso_oe    <= next_miso_oe;
            in_valid   <= next_in_valid;
            in_rw      <= next_in_rw;
            in_addr    <= next_in_addr;
            in_data    <= next_in_data;
            frame_err  <= next_frame_err;
            crc_err    <= next_crc_err;
        end
    end

    // Outgoing buffer: consumed at each frame start, a load from the logic wins over that.
    always_comb begin
        next_ob_kind = ob_kind;
        next_ob_word = ob_word;
        if (cs_start) begin
            next_ob_kind = spicr_pkg::OB_STALE; // R8
        end
        if (cs_end && frame_live && !len_bad && crc_bad) begin
            next_ob_kind = spicr_pkg::OB_CRCERR; // R6
            next_ob_word = spicr_pkg::RESP_ONES;
        end
        if (load_ok) begin
            next_ob_kind = spicr_pkg::OB_VALID; // R9 R10 R14
            next_ob_word = {out_rw, out_addr, out_data};
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            ob_kind <= spicr_pkg::OB_STALE;
            ob_word <= 16'hFFFF;
        end else begin
            ob_kind <= next_ob_kind;
            ob_word <= next_ob_word;
        end
    end

    // Command watchdog: flags a command that the logic has not answered in time.
    always_comb begin
        next_cmd_cnt  = cmd_cnt;
        next_cmd_wait = cmd_wait;
        next_cmd_late = 1'b0;
        if (in_valid) begin
            next_cmd_cnt  = spicr_pkg::TMR_W'(CMD_CYC - 1); // R12
            next_cmd_wait = 1'b1;
        end else if (load_ok) begin
            next_cmd_wait = 1'b0;
        end else if (cmd_wait) begin
            if (cmd_cnt == '0) begin
                next_cmd_late = 1'b1; // R12
                next_cmd_wait = 1'b0;
            end else begin
                next_cmd_cnt = cmd_cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            cmd_cnt  <= '0;
            cmd_wait <= 1'b0;
            cmd_late <= 1'b0;
        end else begin
            cmd_cnt  <= next_cmd_cnt;
            cmd_wait <= next_cmd_wait;
            cmd_late <= next_cmd_late;
        end
    end

    // Subcommand fill timer; reads of the window stay stale until it runs out.
    always_comb begin
        next_sub_cnt  = sub_cnt;
        next_sub_busy = sub_busy;
        if (sub_fill_start) begin
            next_sub_cnt  = spicr_pkg::TMR_W'(SUB_CYC - 1); // R13
            next_sub_busy = 1'b1;
        end else if (sub_busy) begin
            if (sub_cnt == '0) begin
                next_sub_busy = 1'b0;
            end else begin
                next_sub_cnt = sub_cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sub_cnt  <= '0;
            sub_busy <= 1'b0;
        end else begin
            sub_cnt  <= next_sub_cnt;
            sub_busy <= next_sub_busy;
        end
    end

    // Checks on the behaviour above.
    sequence seq_frame_open;
        cs_start && osc_ready;
    endsequence

    sequence seq_fill_begin;
        sub_fill_start;
    endsequence

    a_miso_drive_frame: assert property (@(posedge clk) disable iff (!nrst) // R7
        cs_start |=> miso_oe && (miso == tx_sh[23]))
        else $error("output not driven with first response bit");

    a_osc_off_ones: assert property (@(posedge clk) disable iff (!nrst) // R21
        (cs_start && !osc_ready) |=> (tx_sh == 24'hFFFFFF) && !frame_live)
        else $error("oscillator-off frame not all ones");

    a_stale_reply: assert property (@(posedge clk) disable iff (!nrst) // R8
        (seq_frame_open ##0 (ob_kind == spicr_pkg::OB_STALE)) |=> (tx_sh == 24'hFFFF00))
        else $error("stale buffer not answered with FFFF00");

    a_valid_reply_crc: assert property (@(posedge clk) disable iff (!nrst) // R11
        (seq_frame_open ##0 (ob_kind == spicr_pkg::OB_VALID))
        |=> (tx_sh[7:0] == spicr_pkg::spicr_crc8(tx_sh[23:8])) && (tx_sh[23:8] == $past(ob_word)))
        else $error("reply CRC or word wrong");

    a_crc_err_resp: assert property (@(posedge clk) disable iff (!nrst) // R6
        (crc_err && !$past(load_ok)) |-> (ob_kind == spicr_pkg::OB_CRCERR) && (ob_word == 16'hFFFF) && !in_valid)
        else $error("bad CRC did not set error response");

    a_frame_len_err: assert property (@(posedge clk) disable iff (!nrst) // R19
        (cs_end && frame_live && len_bad) |=> frame_err && !in_valid && !crc_err)
        else $error("wrong clock count not flagged");

    a_load_echo: assert property (@(posedge clk) disable iff (!nrst) // R9
        load_ok |=> (ob_kind == spicr_pkg::OB_VALID) && (ob_word == {$past(out_rw), $past(out_addr), $past(out_data)}))
        else $error("loaded reply not held in outgoing buffer");

    a_sub_fill_busy: assert property (@(posedge clk) disable iff (!nrst) // R13
        seq_fill_begin |=> sub_busy [*8])
        else $error("subcommand fill window ended early");

    a_cmd_late_time: assert property (@(posedge clk) disable iff (!nrst) // R12
        cmd_late |-> $past(cmd_wait) && ($past(cmd_cnt) == '0) && !$past(load_ok))
        else $error("late flag without expired wait");

endmodule : spicr_port

// ---- core/spicr_sync.sv ----
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/10ps

module spicr_sync #(
    parameter int         W   = 3,
    parameter logic [2:0] RST = 3'h0
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);

    logic [W-1:0] ff1;
    logic [W-1:0] ff2;
    logic [W-1:0] ff3;
    logic [W-1:0] next_dout;

    // A bit follows only when the last two stages agree, so a late first stage never glitches it.
    always_comb begin
        for (int i = 0; i < W; i++) begin
            next_dout[i] = (ff2[i] == ff3[i]) ? ff3[i] : dout[i];
        end
    end

    // The first stage feeds only the second stage.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ff1  <= RST[W-1:0];
            ff2  <= RST[W-1:0];
            ff3  <= RST[W-1:0];
            dout <= RST[W-1:0];
        end else begin
            ff1  <= din;
            ff2  <= ff1;
            ff3  <= ff2;
            dout <= next_dout;
        end
    end

endmodule : spicr_sync

// ---- sim/spicr_host.sv ----
// Serial bus controller model that frames transfers towards the command port.
`timescale 1ns/10ps

module spicr_host (
    output logic      sclk,
    output logic      cs_n,
    output logic      mosi,
    input  wire logic miso_pin
);
    localparam int HALF_NS = 40;
    logic          retry;

    // The link rests with the clock low and the select high between frames.
    initial begin
        sclk  = 1'b0;
        cs_n  = 1'b1;
        mosi  = 1'b0;
        retry = 1'b0;
    end

    // Bitwise CRC over the two payload bytes, cleared before every use.
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : crc8

    // One frame: data moves while the clock is low, the reply is taken on each rising edge.
    task automatic xfer(input logic [15:0] d, input logic [7:0] flip, input int nbits, output logic [23:0] rx);
        logic [23:0] tx;
        tx = {d, crc8(d) ^ flip};
        rx = 24'h000000;
        #17;
        cs_n = 1'b0;
        #HALF_NS;
        for (int i = 0; i < nbits; i++) begin
            mosi = (i < 24) ? tx[23 - i] : 1'b0;
            #HALF_NS;
            sclk = 1'b1;
            rx   = {rx[22:0], miso_pin};
            #HALF_NS;
            sclk = 1'b0;
        end
        #HALF_NS;
        cs_n = 1'b1;
        // A released data line must not keep looking valid.
        mosi = ~mosi;
        #100;
        // Reserved all-ones replies ask for the previous frame to be sent again.
        retry = (nbits > 16) ? (rx[23:8] == 16'hFFFF) : (rx[15:0] == 16'hFFFF);
    endtask : xfer
endmodule : spicr_host

// ---- sim/tb_spicr_port.sv ----
// Self-checking bench for the serial command port with a controller model on the link.
`timescale 1ns/10ps

module tb_spicr_port;
    localparam int CMD_N = 60;
    localparam int SUB_N = 40;
    logic        clk, nrst, sclk, cs_n, mosi, miso, miso_oe, miso_hold, miso_pin;
    logic        crc_en, osc_ready, in_valid, in_rw, out_load, out_rw, sub_fill_start;
    logic        sub_busy, cmd_late, frame_err, crc_err;
    logic [6:0]  in_addr, out_addr;
    logic [7:0]  in_data, out_data, rd;
    logic [15:0] d;
    logic [23:0] exp_reply, rx;
    logic [31:0] seed, r;
    int          err_count, cmp_count, n_valid, n_crc, n_frm, n_late, n_busy;
    int          e_valid, e_crc, e_frm, e_late;

    spicr_port #(.CMD_CYC(CMD_N), .SUB_CYC(SUB_N)) u_dut (
        .clk(clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe),
        .crc_en(crc_en), .osc_ready(osc_ready), .in_valid(in_valid), .in_rw(in_rw), .in_addr(in_addr),
        .in_data(in_data), .out_load(out_load), .out_rw(out_rw), .out_addr(out_addr), .out_data(out_data),
        .sub_fill_start(sub_fill_start), .sub_busy(sub_busy), .cmd_late(cmd_late), .frame_err(frame_err),
        .crc_err(crc_err)
    );

    spicr_host u_host (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso_pin(miso_pin));

    // The clock toggles every 2.5 ns, half of its 5 ns period.
    always #2.5 clk = ~clk;

    // The undriven reply line shows the inverse of its last level, never a stale copy.
    always @(posedge clk) if (miso_oe === 1'b1) miso_hold <= miso;
    assign miso_pin = (miso_oe === 1'b1) ? miso : ~miso_hold;

    // Pulses are counted here so no single-cycle event is missed by the main sequence.
    always @(posedge clk) begin
        if (in_valid === 1'b1) n_valid++;
        if (crc_err === 1'b1) n_crc++;
        if (frame_err === 1'b1) n_frm++;
        if (cmd_late === 1'b1) n_late++;
        if (sub_busy === 1'b1) n_busy++;
    end

    // Repeatable pseudo-random source.
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    // Reply word with its trailing check byte.
    function automatic logic [23:0] reply_of(input logic [15:0] w);
        return {w, u_host.crc8(w)};
    endfunction : reply_of

    // Counts and reports one comparison.
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // Runs one frame and compares the reply, the retry flag on 16- and 24-bit frames, and the valid, CRC and length tallies.
    task automatic frame(input logic [15:0] w, input logic [7:0] flip, input int nbits, input logic [23:0] exp);
        u_host.xfer(w, flip, nbits, rx);
        // Later inputs then change a fixed delay after a clock edge.
        @(posedge clk);
        #1;
        if (nbits == 24) check("reply", rx, exp);
        if (nbits != 24) check("reply", {8'h00, rx[nbits-1 -: 16]}, {8'h00, exp[23:8]});
        if (nbits == 24 || nbits == 16) check("retry", 24'(u_host.retry), 24'(exp[23:8] == 16'hFFFF));
        check("valid count", 24'(n_valid), 24'(e_valid));
        check("crc count", 24'(n_crc), 24'(e_crc));
        check("length count", 24'(n_frm), 24'(e_frm));
    endtask : frame

    // Loads a reply word from the internal side for one cycle.
    task automatic load(input logic [15:0] w);
        @(posedge clk);
        #1;
        out_load = 1'b1;
        {out_rw, out_addr, out_data} = w;
        @(posedge clk);
        #1;
        out_load = 1'b0;
    endtask : load

    // Prints the verdict and ends the run.
    task automatic summarize();
        if (err_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : summarize

    // Main sequence: random traffic, then the error, wake and fill cases.
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        crc_en = 1'b1;
        osc_ready = 1'b1;
        out_load = 1'b0;
        {out_rw, out_addr, out_data} = 16'h0000;
        sub_fill_start = 1'b0;
        seed = 32'hE4341B75;
        repeat (8) @(posedge clk);
        #1 nrst = 1'b1;
        repeat (4) @(posedge clk);
        exp_reply = 24'hFFFF00;
        for (int m = 0; m < 2; m++) begin
            crc_en = (m == 0);
            for (int k = 0; k < 8; k++) begin
                r = xs();
                d = (k == 0) ? 16'hFF00 : (k == 1) ? 16'h7FFF : r[15:0];
                if (d == 16'hFFFF) d = 16'hFFFE;
                e_valid++;
                frame(d, 8'h00, crc_en ? 24 : 16, exp_reply);
                check("in_rw", 24'(in_rw), 24'(d[15]));
                check("in_addr", 24'(in_addr), 24'(d[14:8]));
                check("in_data", 24'(in_data), 24'(d[15] ? d[7:0] : 8'h00));
                exp_reply = 24'hFFFF00;
                rd = d[15] ? d[7:0] : r[31:24];
                if (r[16]) load({d[15:8], rd});
                if (r[16]) exp_reply = reply_of({d[15:8], rd});
                else e_late++;
            end
        end
        crc_en = 1'b1;
        r = xs();
        d = r[15:0];
        d[15] = 1'b1;
        e_crc++;
        frame(d, 8'h5A, 24, exp_reply);
        e_valid++;
        frame(d, 8'h00, 24, 24'hFFFFAA);
        e_late++;
        e_frm++;
        frame(d, 8'h00, 23, 24'hFFFF00);
        crc_en = 1'b0;
        e_frm++;
        frame(d, 8'h00, 17, 24'hFFFF00);
        crc_en = 1'b1;
        load(16'h1234);
        osc_ready = 1'b0;
        frame(d, 8'h00, 24, 24'hFFFFFF);
        osc_ready = 1'b1;
        e_valid++;
        e_late++;
        frame(d, 8'h00, 24, 24'hFFFF00);
        n_busy = 0;
        @(posedge clk);
        #1 sub_fill_start = 1'b1;
        @(posedge clk);
        #1 sub_fill_start = 1'b0;
        load(16'h4577);
        repeat (4 * SUB_N) @(posedge clk);
        check("busy length", 24'(n_busy), 24'(SUB_N));
        e_valid++;
        frame(16'h4500, 8'h00, 24, 24'hFFFF00);
        load(16'h4577);
        e_valid++;
        e_late++;
        frame(16'h4500, 8'h00, 24, reply_of(16'h4577));
        repeat (CMD_N + 40) @(posedge clk);
        check("late count", 24'(n_late), 24'(e_late));
        summarize();
    end

    // A hung run is cut short and counted as a mismatch.
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        summarize();
    end
endmodule : tb_spicr_port
